// *** include/acs_pkg.sv ***
package acs_pkg;
  localparam int MASK_W          = 16;
  localparam int CHAN_W          = 4;
  localparam int CNT_W           = 5;
  localparam int CTRL_WRITE_BIT  = 15;
  localparam int CTRL_ADDR_HI    = 13;
  localparam int CTRL_ADDR_LO    = 10;
  localparam int CTRL_PM_HI_BIT  = 9;
  localparam int CTRL_PM_LO_BIT  = 8;
  localparam int CTRL_MASK_SEL_BIT = 7;
  localparam int CTRL_SEQUENCE_BIT = 3;
  localparam logic [4:0]  FRAME_BITS  = 5'h10;
  localparam logic [15:0] MASK_RESET  = 16'h0000;
  localparam logic [3:0]  CHAN_RESET  = 4'h0;
  localparam logic [1:0]  PM_NORMAL   = 2'h3;
  localparam logic [1:0]  PM_FULL_OFF = 2'h2;
  localparam logic [1:0]  PM_AUTO_OFF = 2'h1;
  localparam logic [1:0]  PM_AUTO_SBY = 2'h0;
  typedef enum logic [1:0] {
    ACS_MODE_NORMAL,
    ACS_MODE_MASK_LOAD,
    ACS_MODE_MASK_RUN,
    ACS_MODE_CONSEC
  } acs_mode_t;
endpackage

// *** rtl/acs_sequencer.sv ***
// Operation
// - Mask word shifts in on serial input while the previous result shifts out; this block has no result output.
// - Mask loads over sixteen serial clock falling edges, one bit each.
// - Mask stored only if previous control write had sequence 0, mask-select 1.
// - Mask is MSB first; bit 15 is channel 0, bit 0 channel 15.
// - After mask write, each frame-sync fall advances to next selected channel.
// - Selected channels visited ascending, wrapping, until write with pair not 1,0.
// - Normal mode: each control write with pair 0,0 picks the next channel from its address field.
// - Consecutive mode steps channels each transfer without new writes.
// - Power mode 0,1 is auto-shutdown; a dummy cycle precedes a valid conversion.
// - Power mode 0,0 is auto-standby between conversions.
// - Standby wake takes one dummy transfer before a valid one.
// - Sequence 1, mask-select 1 converts channel 0 to address field, repeating.
// - Sequence 1, mask-select 0 updates settings without stopping the sequence.
// - Four-bit address is straight binary, 0000 channel 0 to 1111 channel 15.
`timescale 1ns/10ps
`default_nettype none
module acs_sequencer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        converter_serial_clock,
  input  wire logic        converter_frame_sync,
  input  wire logic        converter_serial_input,
  output logic [3:0]       conv_channel,
  output logic             conv_start,
  output logic             conv_dummy,
  output logic [1:0]       power_mode,
  output logic             sequence_running,
  output logic [15:0]      adc_channel_sequence_mask
);
  // All three link signals are foreign to clk, so each is synchronised before use.
  logic [1:0]         sclk_sync_r;
  logic [1:0]         sclk_sync_nxt;
  logic [1:0]         fs_sync_r;
  logic [1:0]         fs_sync_nxt;
  logic [1:0]         din_sync_r;
  logic [1:0]         din_sync_nxt;
  logic               sclk_d_r;
  logic               sclk_d_nxt;
  logic               fs_d_r;
  logic               fs_d_nxt;

  // Frame group collects the serial word.
  logic [15:0]        shift_r;
  logic [15:0]        shift_nxt;
  logic [4:0]         bits_r;
  logic [4:0]         bits_nxt;
  logic               in_frame_r;
  logic               in_frame_nxt;

  // Control group holds mode, mask, channel pointer and power mode.
  acs_pkg::acs_mode_t mode_r;
  acs_pkg::acs_mode_t mode_nxt;
  logic [15:0]        mask_r;
  logic [15:0]        mask_nxt;
  logic [3:0]         chan_r;
  logic [3:0]         chan_nxt;
  logic [3:0]         last_r;
  logic [3:0]         last_nxt;
  logic [1:0]         pm_r;
  logic [1:0]         pm_nxt;

  // Pulse group marks conversion starts and wake-up conversions.
  logic               asleep_r;
  logic               asleep_nxt;
  logic               start_r;
  logic               start_nxt;
  logic               dummy_r;
  logic               dummy_nxt;

  // Output group keeps every port on a flip-flop.
  logic [3:0]         conv_channel_nxt;
  logic               conv_start_nxt;
  logic               conv_dummy_nxt;
  logic [1:0]         power_mode_nxt;
  logic               sequence_running_nxt;
  logic [15:0]        mask_out_nxt;

  logic               sclk_fall;
  logic               fs_fall;
  logic               fs_rise;
  logic               bit_take;
  logic               word_done;
  logic               ctrl_write;
  logic [1:0]         pair;

  // Next selected channel strictly above cur, wrapping to the lowest selected.
  function automatic logic [3:0] next_masked(input logic [15:0] m, input logic [3:0] cur);
    logic [3:0] res;
    logic       found;
    logic [4:0] c;
    res   = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      c = 5'(cur) + 5'(i);
      if (!found && m[4'(15 - int'(c[3:0]))]) begin
        res   = c[3:0];
        found = 1'b1;
      end
    end
    return res;
  endfunction

  // Channel address field of a control word, in straight binary.
  function automatic logic [3:0] addr_field(input logic [15:0] w);
    return w[acs_pkg::CTRL_ADDR_HI:acs_pkg::CTRL_ADDR_LO];
  endfunction

  function automatic logic [1:0] pm_field(input logic [15:0] w);
    return {w[acs_pkg::CTRL_PM_HI_BIT], w[acs_pkg::CTRL_PM_LO_BIT]};
  endfunction

  // Both automatic power-down modes cost a wake-up conversion.
  function automatic logic auto_idle(input logic [1:0] pm);
    return (pm == acs_pkg::PM_AUTO_OFF) || (pm == acs_pkg::PM_AUTO_SBY);
  endfunction

  // Edges come from the second stage only, so a metastable first stage is never read.
  assign sclk_fall  = sclk_d_r && !sclk_sync_r[1];
  assign fs_fall    = fs_d_r && !fs_sync_r[1];
  assign fs_rise    = !fs_d_r && fs_sync_r[1];
  assign bit_take   = in_frame_r && sclk_fall && (bits_r < acs_pkg::FRAME_BITS) && !fs_fall;
  assign word_done  = in_frame_r && (bits_r == acs_pkg::FRAME_BITS) && !fs_fall;
  assign ctrl_write = shift_r[acs_pkg::CTRL_WRITE_BIT];
  assign pair       = {shift_r[acs_pkg::CTRL_SEQUENCE_BIT], shift_r[acs_pkg::CTRL_MASK_SEL_BIT]};

  // Sync group.
  always_comb begin
    sclk_sync_nxt = {sclk_sync_r[0], converter_serial_clock};
    fs_sync_nxt   = {fs_sync_r[0], converter_frame_sync};
    din_sync_nxt  = {din_sync_r[0], converter_serial_input};
    sclk_d_nxt    = sclk_sync_r[1];
    fs_d_nxt      = fs_sync_r[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // Reset to the idle levels of the pins, so no false edge follows reset.
      sclk_sync_r <= 2'h3;
      fs_sync_r   <= 2'h3;
      din_sync_r  <= 2'h0;
      sclk_d_r    <= 1'b1;
      fs_d_r      <= 1'b1;
    end else begin
      sclk_sync_r <= sclk_sync_nxt;
      fs_sync_r   <= fs_sync_nxt;
      din_sync_r  <= din_sync_nxt;
      sclk_d_r    <= sclk_d_nxt;
      fs_d_r      <= fs_d_nxt;
    end
  end

  // Frame group.
  always_comb begin
    shift_nxt    = shift_r;
    bits_nxt     = bits_r;
    in_frame_nxt = in_frame_r;
    // A frame-sync fall always restarts the collector, even in mid-word.
    if (fs_fall) begin
      in_frame_nxt = 1'b1;
      bits_nxt     = 5'h00;
    end else if (bit_take) begin
      shift_nxt = {shift_r[14:0], din_sync_r[1]};
      bits_nxt  = bits_r + 5'h01;
    end else if (in_frame_r && (fs_rise || word_done)) begin
      // Short frames are ignored rather than half-applied.
      in_frame_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shift_r    <= acs_pkg::MASK_RESET;
      bits_r     <= 5'h00;
      in_frame_r <= 1'b0;
    end else begin
      shift_r    <= shift_nxt;
      bits_r     <= bits_nxt;
      in_frame_r <= in_frame_nxt;
    end
  end

  // Control group.
  always_comb begin
    mode_nxt = mode_r;
    mask_nxt = mask_r;
    chan_nxt = chan_r;
    last_nxt = last_r;
    pm_nxt   = pm_r;
    if (fs_fall) begin
      case (mode_r)
        acs_pkg::ACS_MODE_MASK_RUN: chan_nxt = next_masked(mask_r, chan_r);
        acs_pkg::ACS_MODE_CONSEC:   chan_nxt = (chan_r >= last_r) ? acs_pkg::CHAN_RESET : chan_r + 4'h1;
        default:                    chan_nxt = chan_r;
      endcase
    end else if (word_done) begin
      if (mode_r == acs_pkg::ACS_MODE_MASK_LOAD) begin
        mask_nxt = shift_r;
        mode_nxt = acs_pkg::ACS_MODE_MASK_RUN;
        // The first fall after loading advances, so park one step behind channel 0.
        // A zero mask finds no channel at all, so the pointer then stays at channel 0.
        chan_nxt = (shift_r == 16'h0000) ? acs_pkg::CHAN_RESET : 4'hF;
      end else if (ctrl_write) begin
        pm_nxt = pm_field(shift_r);
        case (pair)
          2'b00: begin
            mode_nxt = acs_pkg::ACS_MODE_NORMAL;
            chan_nxt = addr_field(shift_r);
          end
          2'b01: mode_nxt = acs_pkg::ACS_MODE_MASK_LOAD;
          2'b10: mode_nxt = mode_r;
          default: begin
            mode_nxt = acs_pkg::ACS_MODE_CONSEC;
            last_nxt = addr_field(shift_r);
            chan_nxt = 4'hF;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_r <= acs_pkg::ACS_MODE_NORMAL;
      mask_r <= acs_pkg::MASK_RESET;
      chan_r <= acs_pkg::CHAN_RESET;
      last_r <= acs_pkg::CHAN_RESET;
      pm_r   <= acs_pkg::PM_NORMAL;
    end else begin
      mode_r <= mode_nxt;
      mask_r <= mask_nxt;
      chan_r <= chan_nxt;
      last_r <= last_nxt;
      pm_r   <= pm_nxt;
    end
  end

  // Pulse group.
  always_comb begin
    asleep_nxt = asleep_r;
    start_nxt  = 1'b0;
    dummy_nxt  = 1'b0;
    if (fs_fall) begin
      start_nxt  = 1'b1;
      // A conversion after a power-down idle serves only to wake the converter.
      dummy_nxt  = asleep_r && auto_idle(pm_r);
      asleep_nxt = 1'b0;
    end else if (word_done) begin
      // The mode written by this very word decides how the converter idles after it.
      asleep_nxt = auto_idle(pm_nxt);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asleep_r <= 1'b0;
      start_r  <= 1'b0;
      dummy_r  <= 1'b0;
    end else begin
      asleep_r <= asleep_nxt;
      start_r  <= start_nxt;
      dummy_r  <= dummy_nxt;
    end
  end

  // Output group.
  always_comb begin
    conv_channel_nxt     = chan_r;
    conv_start_nxt       = start_r;
    conv_dummy_nxt       = dummy_r;
    power_mode_nxt       = pm_r;
    sequence_running_nxt = (mode_r == acs_pkg::ACS_MODE_MASK_RUN) || (mode_r == acs_pkg::ACS_MODE_CONSEC);
    mask_out_nxt         = mask_r;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      conv_channel              <= acs_pkg::CHAN_RESET;
      conv_start                <= 1'b0;
      conv_dummy                <= 1'b0;
      power_mode                <= acs_pkg::PM_NORMAL;
      sequence_running          <= 1'b0;
      adc_channel_sequence_mask <= acs_pkg::MASK_RESET;
    end else begin
      conv_channel              <= conv_channel_nxt;
      conv_start                <= conv_start_nxt;
      conv_dummy                <= conv_dummy_nxt;
      power_mode                <= power_mode_nxt;
      sequence_running          <= sequence_running_nxt;
      adc_channel_sequence_mask <= mask_out_nxt;
    end
  end
endmodule
`default_nettype wire

// *** verification/acs_checker.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        converter_frame_sync,
  input wire logic        conv_start,
  input wire logic        conv_dummy,
  input wire logic [1:0]  power_mode,
  input wire logic        sequence_running,
  input wire logic [15:0] adc_channel_sequence_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence fs_fall;
    $fell(converter_frame_sync);
  endsequence
  sequence one_pulse;
    conv_start ##1 !conv_start;
  endsequence
  start_after_fall_a: assert property (fs_fall |-> ##[3:5] one_pulse) else $error("no start pulse");
  start_in_frame_a: assert property (conv_start |-> !$past(converter_frame_sync, 3)) else $error("stray start");
  start_single_a: assert property (conv_start |=> !conv_start) else $error("start too long");
  dummy_low_power_a: assert property (conv_dummy |-> conv_start && !power_mode[1]) else $error("bad dummy");
  mask_then_run_a: assert property (!$stable(adc_channel_sequence_mask) |-> ##[0:2] sequence_running) else $error("no run");
  pm_quiet_a: assert property (!$stable(power_mode) |-> !conv_start) else $error("mode moved at start");
  run_quiet_a: assert property (!$stable(sequence_running) |-> !conv_start) else $error("run flag moved at start");
  reset_values_a: assert property ($rose(rst_n) |-> power_mode == 2'h3 && !sequence_running && !conv_start)
    else $error("outputs not at reset values");
endmodule
bind acs_sequencer acs_checker u_chk (.clk(clk), .rst_n(rst_n), .converter_frame_sync(converter_frame_sync),
  .conv_start(conv_start), .conv_dummy(conv_dummy), .power_mode(power_mode), .sequence_running(sequence_running),
  .adc_channel_sequence_mask(adc_channel_sequence_mask));
`default_nettype wire

// *** verification/acs_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module acs_host_model (
  input  wire logic clk,
  output var logic  converter_serial_clock,
  output var logic  converter_frame_sync,
  output var logic  converter_serial_input
);
  initial begin
    converter_serial_clock = 1'b1;
    converter_frame_sync   = 1'b1;
    converter_serial_input = 1'b0;
  end
  // The serial clock idles high between frames, so no stray falling edge is taken as a bit.
  task automatic xfer(input logic [15:0] w);
    @(posedge clk);
    converter_frame_sync <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      converter_serial_input <= w[i];
      repeat (4) @(posedge clk);
      converter_serial_clock <= 1'b0;
      repeat (4) @(posedge clk);
      converter_serial_clock <= 1'b1;
    end
    converter_frame_sync   <= 1'b1;
    converter_serial_input <= ~w[0];
    repeat (8) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk;
  logic        rst_n;
  logic        sclk, fsync, sdin, start, dummy, run_on, dm_seen;
  logic [3:0]  chan, ch_seen;
  logic [1:0]  pmode;
  logic [15:0] mask;
  int          n_start = 0, err_count = 0, n_compared = 0, a;
  logic [15:0] wt [18] = '{16'h8380, 16'h4208, 16'h0000, 16'h8308, 16'h0000, 16'h0000, 16'h8f00, 16'h0000,
    16'h8b88, 16'h0000, 16'h0000, 16'h0000, 16'h8700, 16'h0000, 16'h8100, 16'h8000, 16'h8300, 16'h0000};
  logic [7:0]  et [18] = '{8'h0f, 8'h80, 8'h11, 8'h16, 8'h1c, 8'h11, 8'h06, 8'h03, 8'h13, 8'h10, 8'h11,
    8'h12, 8'h00, 8'h01, 8'h01, 8'h20, 8'h20, 8'h00};
  acs_host_model u_host (.clk(clk), .converter_serial_clock(sclk), .converter_frame_sync(fsync),
    .converter_serial_input(sdin));
  acs_sequencer u_dut (.clk(clk), .rst_n(rst_n), .converter_serial_clock(sclk), .converter_frame_sync(fsync),
    .converter_serial_input(sdin), .conv_channel(chan), .conv_start(start), .conv_dummy(dummy),
    .power_mode(pmode), .sequence_running(run_on), .adc_channel_sequence_mask(mask));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    if (start === 1'b1) begin
      ch_seen <= chan;
      dm_seen <= dummy;
      n_start <= n_start + 1;
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Each frame must give exactly one start; the table holds {skip, 0, dummy, sequencing, channel}.
  task automatic frame(input logic [15:0] w, input logic [7:0] e);
    int n0;
    n0 = n_start;
    u_host.xfer(w);
    chk("starts", 16'h0001, 16'(n_start - n0));
    if (!e[7])
      chk("dummy run chan", {8'h00, e}, {10'h000, dm_seen, run_on, ch_seen});
  endtask
  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset", 16'h0083, {8'h00, mask === 16'h0000, run_on, chan, pmode});
    u_host.xfer(16'h8300);
    for (a = 1; a < 16; a++)
      frame(16'h8300 | 16'(a << 10), {4'h0, 4'(a - 1)});
    chk("mask", 16'h0000, mask);
    $display("test normal done");
    for (a = 0; a < 18; a++)
      frame(wt[a], et[a]);
    chk("mask", 16'h4208, mask);
    chk("pmode", 16'h0003, {14'h0000, pmode});
    $display("test sequences done");
    finish_test();
  end
endmodule
`default_nettype wire
